// *** rtl/gp_pin.sv ***
`timescale 1ns/1ps
// one pin: mode decode, slow-edge pacing, input path
module gp_pin (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic hold_en,
  input  wire logic fsel_a,
  input  wire logic fsel_b,
  input  wire logic latch,
  input  wire logic dir,
  input  wire logic pin_sync,
  output logic      pin_out,
  output logic      pin_oe_n,
  output logic      pull_up,
  output logic      slow_edge,
  output logic      in_level
);

  logic                         drv_lvl;
  logic                         drv_en;
  logic                         inv;
  gp_pkg::gp_mode_t             mode;
  logic                         lvl_q;
  logic [gp_pkg::SLOW_W-1:0]    slow_cnt_q;

  localparam int SLOW_W = gp_pkg::SLOW_W;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  always_comb begin
    drv_lvl = 1'b0;
    drv_en  = 1'b0;
    inv     = 1'b0;
    mode    = gp_pkg::GP_OPEN;
    if (fsel_b && !dir) begin
      drv_lvl = latch;
      drv_en  = 1'b1;
      mode    = gp_pkg::GP_SLOW;
    end else if (!fsel_a && !fsel_b) begin
      if (dir) begin
        drv_lvl = latch;
        drv_en  = 1'b1;
        mode    = gp_pkg::GP_DRIVE;
      end else if (latch) begin
        mode    = gp_pkg::GP_PULLUP;
      end
    end else if (!fsel_a && fsel_b) begin
      inv     = latch;
      drv_en  = !latch;
      mode    = gp_pkg::GP_OD;
    end else if (fsel_a && !fsel_b && !dir) begin
      drv_en  = 1'b1;
      inv     = latch;
      mode    = gp_pkg::GP_DRIVE;
    end else if (fsel_a && !fsel_b) begin
      drv_lvl = 1'b1;
      drv_en  = 1'b1;
      mode    = gp_pkg::GP_DRIVE;
    end
    // both function bits and dir set: open, no inversion
  end

  // ---------------------------------------------------------------
  // registered pin drive; frozen while in standby
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
      pull_up  <= 1'b0;
      lvl_q    <= 1'b0;
    end else if (!hold_en) begin
      pin_out  <= drv_lvl;
      pin_oe_n <= !drv_en;
      pull_up  <= (mode == gp_pkg::GP_PULLUP);
      lvl_q    <= drv_lvl;
    end
  end

  // slow mode: pacing count loads SLOW_CYC on a change and counts down; slow_edge itself follows the mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      slow_cnt_q <= '0;
    end else if (!hold_en) begin
      if (mode == gp_pkg::GP_SLOW && drv_lvl != lvl_q) begin
        slow_cnt_q <= SLOW_W'(gp_pkg::SLOW_CYC);
      end else if (slow_cnt_q != '0) begin
        slow_cnt_q <= slow_cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      slow_edge <= 1'b0;
    end else if (!hold_en) begin
      slow_edge <= (mode == gp_pkg::GP_SLOW);
    end
  end

  // input path: complemented when inverted input is selected
  assign in_level = pin_sync ^ inv;

endmodule : gp_pin

// *** rtl/gp_pkg.sv ***
package gp_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int          PIN_COUNT   = 4;
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 8;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_LATCH   = 16'h7f4c;
  localparam logic [15:0] OFS_INPUT   = 16'h7f4d;
  localparam logic [15:0] OFS_DIR     = 16'h7f4e;
  localparam logic [15:0] OFS_FSEL_A  = 16'h7f4f;
  localparam logic [15:0] OFS_FSEL_B  = 16'h7ff3;

  // ---------------------------------------------------------------
  // reset values and fill
  // ---------------------------------------------------------------
  localparam logic [3:0]  RST_FIELD   = 4'h0;
  localparam logic [3:0]  UPPER_FILL  = 4'h0;
  localparam logic [7:0]  UNMAP_DATA  = 8'h00;

  // ---------------------------------------------------------------
  // slow edge: SLOW_NS as SLOW_CYC cycles for the pacing count; slow_edge stands for as long as the pin is in slow mode
  // ---------------------------------------------------------------
  localparam int          CLK_HZ      = 40000000;
  localparam int          SLOW_NS     = 200;
  localparam int          SLOW_CYC    = (SLOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          SLOW_W      = 4;

  // per-pin drive modes
  typedef enum logic [2:0] {
    GP_OPEN,
    GP_PULLUP,
    GP_DRIVE,
    GP_SLOW,
    GP_OD
  } gp_mode_t;

endpackage : gp_pkg

// *** rtl/gp_port.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Summary of operation
// - with both selects clear, direction bit per pin enables drive
// - latch gives output level or pull-up request
// - select registers pick each pin's output mode
// - input register reads pin levels always
// - inverted input complements read and irq
// - every pin level feeds its irq line
// - all clear: float, or pull-up when latch 1
// - selects clear, dir set: push-pull latch level
// - select b, dir clear: slow-edge latch level
// - select b and dir: open drain, inverted when 1
// - select a, dir clear: low, latch 1 inverts
// - select a and dir: driven high
// - all set: float, input not inverted
// - standby keeps pin state as entered
// - upper bits read zero, low bits reset zero
// ---------------------------------------------------------------
module gp_port (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  input  wire logic        halt_mode,
  input  wire logic        hold_mode,
  input  wire logic        standby_keep_osc_state,
  input  wire logic [3:0]  port_pins_in,
  output logic      [3:0]  port_pins_out,
  output logic      [3:0]  port_pins_oe_n,
  output logic      [3:0]  port_pins_pull_up,
  output logic      [3:0]  port_pins_slow_edge,
  output logic      [3:0]  external_irq_lines
);

  logic [3:0] pin_output_latch_q;
  logic [3:0] pin_direction_q;
  logic [3:0] pin_function_select_a_q;
  logic [3:0] pin_function_select_b_q;
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] level;
  logic       hold_en;

  // ---------------------------------------------------------------
  // standby freeze
  // ---------------------------------------------------------------
  assign hold_en = halt_mode | hold_mode | standby_keep_osc_state;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_output_latch_q <= gp_pkg::RST_FIELD;
    end else if (bus_wr && bus_addr == gp_pkg::OFS_LATCH) begin
      pin_output_latch_q <= bus_wdata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_direction_q <= gp_pkg::RST_FIELD;
    end else if (bus_wr && bus_addr == gp_pkg::OFS_DIR) begin
      pin_direction_q <= bus_wdata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_function_select_a_q <= gp_pkg::RST_FIELD;
    end else if (bus_wr && bus_addr == gp_pkg::OFS_FSEL_A) begin
      pin_function_select_a_q <= bus_wdata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_function_select_b_q <= gp_pkg::RST_FIELD;
    end else if (bus_wr && bus_addr == gp_pkg::OFS_FSEL_B) begin
      pin_function_select_b_q <= bus_wdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // pin synchroniser; first stage read only by the second
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= port_pins_in;
      sync_q <= meta_q;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  for (genvar i = 0; i < gp_pkg::PIN_COUNT; i++) begin : g_pin
    gp_pin u_pin (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .hold_en   (hold_en),
      .fsel_a    (pin_function_select_a_q[i]),
      .fsel_b    (pin_function_select_b_q[i]),
      .latch     (pin_output_latch_q[i]),
      .dir       (pin_direction_q[i]),
      .pin_sync  (sync_q[i]),
      .pin_out   (port_pins_out[i]),
      .pin_oe_n  (port_pins_oe_n[i]),
      .pull_up   (port_pins_pull_up[i]),
      .slow_edge (port_pins_slow_edge[i]),
      .in_level  (level[i])
    );
  end

  // irq lines follow the input level, complemented where inverted input is selected, registered for a clean data output
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      external_irq_lines <= 4'h0;
    end else begin
      external_irq_lines <= level;
    end
  end

  // ---------------------------------------------------------------
  // read port: data in the cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_rdata <= gp_pkg::UNMAP_DATA;
    end else if (bus_rd) begin
      if (bus_addr == gp_pkg::OFS_LATCH) begin
        bus_rdata <= {gp_pkg::UPPER_FILL, pin_output_latch_q};
      end else if (bus_addr == gp_pkg::OFS_INPUT) begin
        bus_rdata <= {gp_pkg::UPPER_FILL, level};
      end else if (bus_addr == gp_pkg::OFS_DIR) begin
        bus_rdata <= {gp_pkg::UPPER_FILL, pin_direction_q};
      end else if (bus_addr == gp_pkg::OFS_FSEL_A) begin
        bus_rdata <= {gp_pkg::UPPER_FILL, pin_function_select_a_q};
      end else if (bus_addr == gp_pkg::OFS_FSEL_B) begin
        bus_rdata <= {gp_pkg::UPPER_FILL, pin_function_select_b_q};
      end else begin
        bus_rdata <= gp_pkg::UNMAP_DATA;
      end
    end else begin
      bus_rdata <= gp_pkg::UNMAP_DATA;
    end
  end

endmodule : gp_port

// *** verification/gp_pins_model.sv ***
`timescale 1ns/1ps
module gp_pins_model (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe_n,
  input  wire logic [3:0] ext_val,
  output logic      [3:0] pin_level
);
  // board pushes ext_val onto every pin the port leaves undriven
  assign pin_level = (pin_oe_n & ext_val) | (~pin_oe_n & pin_out);
endmodule : gp_pins_model

// *** verification/gp_port_sva.sv ***
`timescale 1ns/1ps
module gp_port_sva (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic        halt_mode,
  input wire logic        hold_mode,
  input wire logic        standby_keep_osc_state,
  input wire logic [3:0]  port_pins_out,
  input wire logic [3:0]  port_pins_oe_n,
  input wire logic [3:0]  port_pins_pull_up,
  input wire logic [3:0]  port_pins_slow_edge,
  input wire logic [3:0]  external_irq_lines
);
  logic [3:0] dir_q;
  logic [3:0] lat_q;
  logic       sb;
  assign sb = halt_mode | hold_mode | standby_keep_osc_state;
  // shadow copies so readback can be judged without seeing the body
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dir_q <= 4'h0;
      lat_q <= 4'h0;
    end else if (bus_wr && bus_addr == gp_pkg::OFS_DIR) begin
      dir_q <= bus_wdata[3:0];
    end else if (bus_wr && bus_addr == gp_pkg::OFS_LATCH) begin
      lat_q <= bus_wdata[3:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // --------------------------------------------------
  // properties
  // --------------------------------------------------
  a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_upper_zero: assert property (bus_rdata[7:4] == 4'h0)
    else $error("upper read bits not zero");
  a_dir_readback: assert property ($past(bus_rd) && $past(bus_addr) == gp_pkg::OFS_DIR
    |-> bus_rdata == {4'h0, $past(dir_q)}) else $error("direction readback wrong");
  a_latch_readback: assert property ($past(bus_rd) && $past(bus_addr) == gp_pkg::OFS_LATCH
    |-> bus_rdata == {4'h0, $past(lat_q)}) else $error("latch readback wrong");
  a_pull_undriven: assert property ((port_pins_pull_up & ~port_pins_oe_n) == 4'h0)
    else $error("pull-up on a driven pin");
  a_slow_drives: assert property ((port_pins_slow_edge & port_pins_oe_n) == 4'h0)
    else $error("slow edge on an undriven pin");
  a_standby_frozen: assert property (sb && $past(sb) && $past(sb, 2) |->
    $stable(port_pins_out) && $stable(port_pins_oe_n) && $stable(port_pins_pull_up))
    else $error("pin state moved in standby");
  a_reset_quiet: assert property ($past(sys_rst) |-> port_pins_oe_n == 4'hf
    && port_pins_out == 4'h0 && external_irq_lines == 4'h0) else $error("pins not idle");
endmodule : gp_port_sva

bind gp_port gp_port_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .halt_mode(halt_mode), .hold_mode(hold_mode),
  .standby_keep_osc_state(standby_keep_osc_state), .port_pins_out(port_pins_out),
  .port_pins_oe_n(port_pins_oe_n), .port_pins_pull_up(port_pins_pull_up),
  .port_pins_slow_edge(port_pins_slow_edge), .external_irq_lines(external_irq_lines));

// *** verification/gp_port_tb_top.sv ***
`timescale 1ns/1ps
module gp_port_tb_top;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [7:0]  bus_rdata;
  logic [2:0]  sb = 3'h0;
  logic [3:0]  ext_val = 4'h6;
  logic [3:0]  lvl, p_out, p_oe_n, p_pu, p_sl, irq, lv;
  logic [4:0]  e;
  int          mismatches = 0;
  int          checks_done = 0;
  // per mode {fsel_a, fsel_b, latch, dir}: {oe_n, out, pull, slow, invert}
  logic [4:0]  tbl [16] = '{5'h10, 5'h00, 5'h14, 5'h08, 5'h02, 5'h00, 5'h0a, 5'h11,
                            5'h00, 5'h08, 5'h01, 5'h08, 5'h02, 5'h10, 5'h0a, 5'h10};
  logic [15:0] rw [4] = '{gp_pkg::OFS_LATCH, gp_pkg::OFS_DIR, gp_pkg::OFS_FSEL_A,
                          gp_pkg::OFS_FSEL_B};
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  gp_port dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .halt_mode(sb[0]), .hold_mode(sb[1]), .standby_keep_osc_state(sb[2]),
    .port_pins_in(lvl), .port_pins_out(p_out), .port_pins_oe_n(p_oe_n),
    .port_pins_pull_up(p_pu), .port_pins_slow_edge(p_sl), .external_irq_lines(irq));
  gp_pins_model u_pins (.pin_out(p_out), .pin_oe_n(p_oe_n), .ext_val(ext_val),
    .pin_level(lvl));
  // --------------------------------------------------
  // bus access and checking
  // --------------------------------------------------
  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : cmp
  // strobe left high so writes can follow each other; idle drops it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    bus_rd <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
    bus_addr <= a;
    bus_rd <= 1'b1;
    bus_wr <= 1'b0;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    cmp(nm, exp, bus_rdata);
    @(posedge ref_clk);
  endtask : rd
  task automatic idle(input int n);
    bus_wr <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    foreach (rw[i]) rd(rw[i], 8'h00, "reset value");
    foreach (rw[i]) begin
      wr(rw[i], 8'hff);
      rd(rw[i], 8'h0f, "readback");
    end
    rd(16'h7f50, 8'h00, "unmapped");
    wr(gp_pkg::OFS_INPUT, 8'h0f);
    rd(gp_pkg::OFS_INPUT, 8'h06, "input read only");
    for (int p = 0; p < 2; p++) begin
      ext_val <= p ? 4'h9 : 4'h6;
      for (int m = 0; m < 16; m++) begin
        wr(gp_pkg::OFS_DIR, {4'h0, {4{m[0]}}});
        wr(gp_pkg::OFS_FSEL_A, {4'h0, {4{m[3]}}});
        wr(gp_pkg::OFS_FSEL_B, {4'h0, {4{m[2]}}});
        wr(gp_pkg::OFS_LATCH, {4'h0, {4{m[1]}}});
        idle(12);
        e = tbl[m];
        lv = e[4] ? ext_val : {4{e[3]}};
        cmp("oe_n", {4'h0, {4{e[4]}}}, {4'h0, p_oe_n});
        if (!e[4]) cmp("out", {4'h0, {4{e[3]}}}, {4'h0, p_out});
        cmp("pull", {4'h0, {4{e[2]}}}, {4'h0, p_pu});
        cmp("slow", {4'h0, {4{e[1]}}}, {4'h0, p_sl});
        cmp("irq", {4'h0, lv ^ {4{e[0]}}}, {4'h0, irq});
        rd(gp_pkg::OFS_INPUT, {4'h0, lv ^ {4{e[0]}}}, "level");
      end
    end
    wr(gp_pkg::OFS_FSEL_A, 8'h00);
    wr(gp_pkg::OFS_FSEL_B, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(gp_pkg::OFS_LATCH, 8'h0f);
      idle(3);
      sb <= 3'h1 << i;
      idle(2);
      wr(gp_pkg::OFS_LATCH, 8'h00);
      idle(4);
      cmp("held", 8'h0f, {4'h0, p_out});
      sb <= 3'h0;
      idle(4);
      cmp("released", 8'h00, {4'h0, p_out});
    end
    end_sim();
  end
endmodule : gp_port_tb_top
